// ==== analog_comparator_ctrl.sv ====
// Summary of operation
// R1 - Comparator 1 bit 4 picks bandgap reference when set, pin when clear
// R2 - Comparator 1 bit 2 turns hysteresis on; clear at reset
// R3 - Comparator 1 bit 1 lets its change flag raise the interrupt
// R4 - Software waits 2 us after enabling before trusting the output
// R5 - Status bits 3 and 2 show synchronized outputs, zero when disabled
// R6 - Any change of a synchronized output sets its change flag
// R7 - Interrupt is high while a flag, its enable and its mask bit are all set
// R8 - Writing one clears a change flag, writing zero leaves it
// R9 - Both comparators share one interrupt line
// R10 - Comparator 0 control uses the same field layout as comparator 1
// R11 - Output is one when positive input exceeds negative input
// R12 - Disabled comparator reads zero and the forced value flags nothing
`timescale 1ns/1ps
`default_nettype none
`include "cmp_ctrl_map.svh"

module analog_comparator_ctrl (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [1:0] CMP_OUT_ASYNC,
    output logic [1:0] CMP_ENABLE,
    output logic [1:0] CMP_NEG_REF,
    output logic [1:0] CMP_HYST_ON,
    output logic CMP_IRQ
);

    // ======================================================
    // Address decode
    function automatic cmp_ctrl_pkg::reg_index_type reg_index(
        input logic [11:0] addr
    );
        if (addr == `CMP_OFS_CTRL0) begin
            reg_index = cmp_ctrl_pkg::REG_CTRL0;
        end else if (addr == `CMP_OFS_CTRL1) begin
            reg_index = cmp_ctrl_pkg::REG_CTRL1;
        end else if (addr == `CMP_OFS_STATUS) begin
            reg_index = cmp_ctrl_pkg::REG_STATUS;
        end else if (addr == `CMP_OFS_MASK) begin
            reg_index = cmp_ctrl_pkg::REG_MASK;
        end else if (addr == `CMP_OFS_SETTLE) begin
            reg_index = cmp_ctrl_pkg::REG_SETTLE;
        end else begin
            reg_index = cmp_ctrl_pkg::REG_NONE;
        end
    endfunction : reg_index

    cmp_ctrl_pkg::apb_phase_type phase_r;
    cmp_ctrl_pkg::reg_index_type acc_idx;
    cmp_ctrl_pkg::ctrl_field_type ctrl_r [2];
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic pready_r;
    logic pslverr_r;
    logic wr_commit;
    logic [1:0] mask_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] out_r;
    logic [1:0] flag_r;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [1:0] en_d_r;
    logic [1:0] armed_r;
    logic [1:0] settled_r;
    logic [1:0] en_w;
    logic [1:0] ie_w;
    logic irq_r;

    assign acc_idx = reg_index(PADDR);
    // Writes land only at the edge where the master sees PREADY
    assign wr_commit = PSEL && PENABLE && PWRITE && PSTRB[0] &&
        (phase_r == cmp_ctrl_pkg::APB_ACK) && CLK_EN;

    // ======================================================
    // APB handshake
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            phase_r <= cmp_ctrl_pkg::APB_IDLE;
        end else if (CLK_EN) begin
            case (phase_r)
                cmp_ctrl_pkg::APB_IDLE: begin
                    if (PSEL && PENABLE) begin
                        phase_r <= cmp_ctrl_pkg::APB_ACK;
                    end
                end
                cmp_ctrl_pkg::APB_ACK: begin
                    phase_r <= cmp_ctrl_pkg::APB_IDLE;
                end
                default: begin
                    phase_r <= cmp_ctrl_pkg::APB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (CLK_EN) begin
            pready_r <= (phase_r == cmp_ctrl_pkg::APB_IDLE) &&
                PSEL && PENABLE;
            if ((phase_r == cmp_ctrl_pkg::APB_IDLE) && PSEL &&
                    PENABLE) begin
                pslverr_r <= (acc_idx == cmp_ctrl_pkg::REG_NONE);
                prdata_r <= PWRITE ? 32'h0000_0000 : rdata_nxt;
            end else begin
                pslverr_r <= 1'b0;
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // ======================================================
    // Read mux
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (acc_idx)
            cmp_ctrl_pkg::REG_CTRL0: begin
                rdata_nxt[4:0] = ctrl_r[0];
            end
            cmp_ctrl_pkg::REG_CTRL1: begin
                rdata_nxt[4:0] = ctrl_r[1];
            end
            cmp_ctrl_pkg::REG_STATUS: begin
                rdata_nxt[`CMP_BIT_OUT0 +: 2] = out_r; // R5
                rdata_nxt[`CMP_BIT_FLAG0 +: 2] = flag_r;
            end
            cmp_ctrl_pkg::REG_MASK: begin
                rdata_nxt[1:0] = mask_r;
            end
            cmp_ctrl_pkg::REG_SETTLE: begin
                rdata_nxt[1:0] = settled_r;
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // ======================================================
    // Interrupt mask
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_r <= `CMP_MASK_RESET;
        end else if (wr_commit &&
                acc_idx == cmp_ctrl_pkg::REG_MASK) begin
            mask_r <= PWDATA[1:0];
        end
    end

    // ======================================================
    // Per comparator channel
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_cmp
            logic [`CMP_SETTLE_W-1:0] settle_cnt_r;

            assign en_w[ch] = ctrl_r[ch][`CMP_BIT_EN];
            assign ie_w[ch] = ctrl_r[ch][`CMP_BIT_IE]; // R3

            // Same layout for both channels
            always_ff @(posedge CORE_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    ctrl_r[ch] <= `CMP_CTRL_RESET; // R2
                end else if (wr_commit && acc_idx ==
                        cmp_ctrl_pkg::reg_index_type'(ch)) begin
                    ctrl_r[ch] <= PWDATA[4:0] & `CMP_CTRL_KEEP; // R10
                end
            end

            // Analog output is asynchronous to the bus clock
            always_ff @(posedge CORE_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    sync1_r[ch] <= 1'b0;
                    sync2_r[ch] <= 1'b0;
                end else if (CLK_EN) begin
                    sync1_r[ch] <= CMP_OUT_ASYNC[ch]; // R11
                    sync2_r[ch] <= sync1_r[ch];
                end
            end

            // Sync stages hold samples from the disabled time for two
            // edges after enable, so the output stays forced meanwhile
            always_ff @(posedge CORE_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    armed_r[ch] <= 1'b0;
                    out_r[ch] <= 1'b0;
                end else if (CLK_EN) begin
                    armed_r[ch] <= en_d_r[ch] & en_w[ch]; // R12
                    out_r[ch] <= en_w[ch] & armed_r[ch] &
                        sync2_r[ch]; // R5 R12
                end
            end

            // Forced zero on disable is not a real edge
            assign flag_set[ch] = CLK_EN && en_w[ch] && armed_r[ch] &&
                (sync2_r[ch] != out_r[ch]); // R6 R12
            assign flag_clr[ch] = wr_commit &&
                (acc_idx == cmp_ctrl_pkg::REG_STATUS) &&
                PWDATA[`CMP_BIT_FLAG0 + ch]; // R8

            // Set beats clear so no edge is lost
            always_ff @(posedge CORE_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    flag_r[ch] <= 1'b0;
                end else if (flag_set[ch]) begin
                    flag_r[ch] <= 1'b1; // R6
                end else if (flag_clr[ch]) begin
                    flag_r[ch] <= 1'b0; // R8
                end
            end

            // Settle tracker only informs software, it gates nothing
            always_ff @(posedge CORE_CLK or negedge RESETN) begin
                if (!RESETN) begin
                    en_d_r[ch] <= 1'b0;
                    settle_cnt_r <= '0;
                    settled_r[ch] <= 1'b0;
                end else if (CLK_EN) begin
                    en_d_r[ch] <= en_w[ch];
                    if (!en_w[ch]) begin
                        settle_cnt_r <= '0;
                        settled_r[ch] <= 1'b0;
                    end else if (!en_d_r[ch]) begin
                        settle_cnt_r <= `CMP_SETTLE_W'(
                            `CMP_SETTLE_CYCLES - 1); // R4
                        settled_r[ch] <= 1'b0;
                    end else if (settle_cnt_r != '0) begin
                        settle_cnt_r <= settle_cnt_r - 1'b1;
                    end else begin
                        settled_r[ch] <= 1'b1;
                    end
                end
            end

            assign CMP_ENABLE[ch] = ctrl_r[ch][`CMP_BIT_EN];
            assign CMP_NEG_REF[ch] = ctrl_r[ch][`CMP_BIT_NEG_SEL]; // R1
            assign CMP_HYST_ON[ch] = ctrl_r[ch][`CMP_BIT_HYST]; // R2
        end
    endgenerate

    // ======================================================
    // Shared interrupt
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_r <= 1'b0;
        end else if (CLK_EN) begin
            irq_r <= |(flag_r & ie_w & mask_r); // R3 R7 R9
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = pready_r;
    assign PSLVERR = pslverr_r;
    assign CMP_IRQ = irq_r;

    // ======================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    a_neg_select_ch1: assert property ( // R1
        wr_commit && acc_idx == cmp_ctrl_pkg::REG_CTRL1
        |=> CMP_NEG_REF[1] == $past(PWDATA[4])
    ) else $error("negative select of ch1 not taken");

    a_hyst_ch1: assert property ( // R2
        wr_commit && acc_idx == cmp_ctrl_pkg::REG_CTRL1
        |=> CMP_HYST_ON[1] == $past(PWDATA[2])
    ) else $error("hysteresis of ch1 not taken");

    a_irq_blocked: assert property ( // R3
        CLK_EN && !(flag_r[0] && ie_w[0]) &&
        !(flag_r[1] && ie_w[1]) |=> !CMP_IRQ
    ) else $error("interrupt without enabled flag");

    a_out_disabled: assert property ( // R5
        CLK_EN && !en_w[0] && !en_w[1] |=> out_r == 2'h0
    ) else $error("disabled output not zero");

    a_flag_on_edge: assert property ( // R6
        CLK_EN && $past(CLK_EN) && en_w[1] && armed_r[1] &&
        $past(armed_r[1]) && $changed(sync2_r[1])
        |-> ##1 flag_r[1]
    ) else $error("output change did not set flag");

    a_irq_raise: assert property ( // R7
        CLK_EN && |(flag_r & ie_w & mask_r) |=> CMP_IRQ
    ) else $error("enabled flag did not raise interrupt");

    a_flag_clear: assert property ( // R8
        flag_clr[0] && !flag_set[0] |=> !flag_r[0]
    ) else $error("write one did not clear flag");

    a_clear_keep: assert property ( // R8
        wr_commit && acc_idx == cmp_ctrl_pkg::REG_STATUS &&
        !PWDATA[1] && flag_r[1] |=> flag_r[1]
    ) else $error("write zero changed flag");

    a_single_line: assert property ( // R9
        $past(CLK_EN) && $past(flag_r[0] && ie_w[0] && mask_r[0])
        |-> CMP_IRQ
    ) else $error("ch0 flag missing from shared line");

    a_layout_ch0: assert property ( // R10
        wr_commit && acc_idx == cmp_ctrl_pkg::REG_CTRL0
        |=> CMP_ENABLE[0] == $past(PWDATA[0]) &&
            CMP_HYST_ON[0] == $past(PWDATA[2]) &&
            CMP_NEG_REF[0] == $past(PWDATA[4])
    ) else $error("ch0 layout mismatch");

    a_out_follows: assert property ( // R11
        CLK_EN && en_w[0] && armed_r[0] |=> out_r[0] == $past(sync2_r[0])
    ) else $error("output does not follow comparator");

    a_no_forced_flag: assert property ( // R12
        CLK_EN && !en_w[1] && !flag_r[1] |=> !flag_r[1]
    ) else $error("disabled channel raised flag");

    a_stale_sync: assert property ( // R12
        CLK_EN && $rose(en_w[0]) |-> !flag_set[0] ##1 !flag_set[0]
    ) else $error("stale sample after enable raised flag");

    a_apb_answer: assert property (
        CLK_EN && PSEL && PENABLE && !PREADY |=> PREADY
    ) else $error("bus answer late");

    c_flag_set: cover property (flag_set[0] ##1 flag_r[0]);
    c_irq_high: cover property (!CMP_IRQ ##1 CMP_IRQ);
    c_bad_addr: cover property (PREADY && PSLVERR);
    c_set_clear: cover property (flag_set[1] && flag_clr[1]);

endmodule : analog_comparator_ctrl

`default_nettype wire

// ==== cmp_ctrl_map.svh ====
`ifndef CMP_CTRL_MAP_SVH
`define CMP_CTRL_MAP_SVH

// ==========================================================
// Register offsets
`define CMP_OFS_CTRL0 12'h000
`define CMP_OFS_CTRL1 12'h004
`define CMP_OFS_STATUS 12'h008
`define CMP_OFS_MASK 12'h00c
`define CMP_OFS_SETTLE 12'h010

// ==========================================================
// Control field positions
`define CMP_BIT_NEG_SEL 4
`define CMP_BIT_HYST 2
`define CMP_BIT_IE 1
`define CMP_BIT_EN 0
`define CMP_CTRL_KEEP 5'h17

// ==========================================================
// Status field positions
`define CMP_BIT_FLAG0 0
`define CMP_BIT_OUT0 2

// ==========================================================
// Reset values
`define CMP_CTRL_RESET 5'h00
`define CMP_MASK_RESET 2'h3

// ==========================================================
// Settle timing
`define CMP_SETTLE_TIME_NS 2000
`define CMP_CLK_PERIOD_PS 4000
`define CMP_SETTLE_CYCLES ((`CMP_SETTLE_TIME_NS * 1000 + \
    `CMP_CLK_PERIOD_PS - 1) / `CMP_CLK_PERIOD_PS)
`define CMP_SETTLE_W 9

`endif

// ==== cmp_ctrl_pkg.sv ====
`default_nettype none

package cmp_ctrl_pkg;

    // ======================================================
    // Types
    typedef enum logic [0:0] {
        APB_IDLE = 1'b0,
        APB_ACK = 1'b1
    } apb_phase_type;

    typedef enum logic [2:0] {
        REG_CTRL0 = 3'b000,
        REG_CTRL1 = 3'b001,
        REG_STATUS = 3'b010,
        REG_MASK = 3'b011,
        REG_SETTLE = 3'b100,
        REG_NONE = 3'b111
    } reg_index_type;

    typedef logic [4:0] ctrl_field_type;

endpackage : cmp_ctrl_pkg

`default_nettype wire

// ==== cmp_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two comparators on the analog side, levels in millivolts
module cmp_analog_model #(
    parameter int BANDGAP_MV = 1200,
    parameter int HYST_MV = 20
) (
    input wire logic [1:0] enable,
    input wire logic [1:0] neg_ref,
    input wire logic [1:0] hyst_on,
    input wire logic [31:0] pos_mv,
    input wire logic [31:0] pin_mv,
    output logic [1:0] raw_out
);
    for (genvar i = 0; i < 2; i++) begin : g_ch
        logic lvl = 1'b0;
        int p;
        int r;
        always @* begin
            p = int'(pos_mv[16*i +: 16]);
            r = neg_ref[i] ? BANDGAP_MV : int'(pin_mv[16*i +: 16]);
            if (enable[i] && hyst_on[i]) begin
                lvl = lvl ? (p > r - HYST_MV) : (p > r + HYST_MV);
            end else if (enable[i]) begin
                lvl = p > r;
            end
        end
        // Switched off: show the inverse so a stale copy cannot pass
        assign raw_out[i] = enable[i] ? lvl : ~lvl;
    end
endmodule : cmp_analog_model
`default_nettype wire

// ==== analog_comparator_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module analog_comparator_ctrl_tb;
    localparam int BG = 1200;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] en_o;
    logic [1:0] ref_o;
    logic [1:0] hys_o;
    logic [1:0] raw;
    logic [31:0] pos = 32'h0;
    logic [31:0] pin = 32'h0;
    logic [4:0] ctl [2] = '{5'h00, 5'h00};
    logic [1:0] flg = 2'h0;
    logic [1:0] msk = 2'h3;
    logic [1:0] lv = 2'h0;
    logic [1:0] eo = 2'h0;
    logic [31:0] seed = 32'h7213;
    logic [39:0] q [$];
    logic [39:0] nt;
    int mismatches = 0;
    int total_checks = 0;

    always #2 clk = ~clk;

    analog_comparator_ctrl i_analog_comparator_ctrl (
        .CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .CMP_OUT_ASYNC(raw), .CMP_ENABLE(en_o), .CMP_NEG_REF(ref_o),
        .CMP_HYST_ON(hys_o), .CMP_IRQ(irq));
    cmp_analog_model #(.BANDGAP_MV(BG), .HYST_MV(20)) i_cmp_analog_model (
        .enable(en_o), .neg_ref(ref_o), .hyst_on(hys_o), .pos_mv(pos),
        .pin_mv(pin), .raw_out(raw));

    // ======================================================
    // Helpers
    function automatic logic [31:0] rnd(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : rnd

    function automatic logic [39:0] note(input logic [31:0] d, input logic e);
        logic [1:0] ie;
        ie = {ctl[1][1], ctl[0][1]};
        return {|(flg & ie & msk), e, ctl[1][0], ctl[0][0], ctl[1][4],
            ctl[0][4], ctl[1][2], ctl[0][2], d};
    endfunction : note

    task automatic close_out();
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    // Writes read back zero; outputs noted before the write lands
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] e, input logic err);
        q.push_back(note(w ? 32'h0 : e, err));
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic settle();
        int p;
        int r;
        repeat (8) @(posedge clk);
        for (int c = 0; c < 2; c++) begin
            p = int'(pos[16*c +: 16]);
            r = ctl[c][4] ? BG : int'(pin[16*c +: 16]);
            if (ctl[c][0] && ctl[c][2]) begin
                lv[c] = lv[c] ? p > r - 20 : p > r + 20;
            end else if (ctl[c][0]) begin
                lv[c] = p > r;
            end
            if (ctl[c][0] && lv[c] != eo[c]) flg[c] = 1'b1;
            eo[c] = ctl[c][0] & lv[c];
        end
    endtask : settle

    task automatic set(input int c, input logic [15:0] p, input logic [15:0] n);
        @(posedge clk);
        pos[16*c +: 16] <= p;
        pin[16*c +: 16] <= n;
        settle();
    endtask : set

    task automatic wctl(input int c, input logic [31:0] v);
        logic up;
        up = v[0] & ~ctl[c][0];
        apb(1'b1, 12'(4 * c), v, 32'h0, 1'b0);
        ctl[c] = v[4:0] & 5'h17;
        if (up) repeat (500) @(posedge clk);
        settle();
    endtask : wctl

    task automatic rs();
        apb(1'b0, 12'h008, 32'h0, {28'h0, eo, flg}, 1'b0);
    endtask : rs

    // Output bits are read-only, so writing ones there must do nothing
    task automatic clr(input logic [1:0] v);
        apb(1'b1, 12'h008, {28'h0, 2'h3, v}, 32'h0, 1'b0);
        flg = flg & ~v;
    endtask : clr

    // ======================================================
    // Result watcher
    always @(posedge clk) begin
        if (pready === 1'b1) begin
            nt = q.size() > 0 ? q.pop_front() : 40'h0;
            `CHK({irq, pslverr, en_o, ref_o, hys_o, prdata}, nt)
        end
    end

    initial begin
        #200000;
        mismatches++;
        close_out();
    end

    // ======================================================
    // Scenarios
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
        rs();
        apb(1'b0, 12'h00c, 32'h0, 32'h3, 1'b0);
        apb(1'b0, 12'h014, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h006, 32'h0, 32'h0, 1'b1);
        for (int c = 0; c < 2; c++) begin
            set(c, 16'd1000, 16'd1500);
            wctl(c, 32'h3);
            set(c, 16'd2000, 16'd1500);
            rs();
            clr(2'h0);
            rs();
            clr(2'(1 << c));
            set(c, 16'd1000, 16'd1500);
            rs();
        end
        clr(2'h1);
        rs();
        apb(1'b1, 12'h00c, 32'h0, 32'h0, 1'b0);
        msk = 2'h0;
        rs();
        apb(1'b1, 12'h00c, 32'h3, 32'h0, 1'b0);
        msk = 2'h3;
        wctl(1, 32'h1);
        rs();
        wctl(1, 32'h3);
        rs();
        clr(2'h3);
        set(1, 16'd2000, 16'd3000);
        wctl(1, 32'h13);
        rs();
        wctl(1, 32'h3);
        set(1, 16'd3500, 16'd3000);
        wctl(1, 32'h7);
        set(1, 16'd2990, 16'd3000);
        rs();
        wctl(1, 32'h3);
        rs();
        clr(2'h3);
        set(0, 16'd2000, 16'd1500);
        clr(2'h3);
        wctl(0, 32'h0);
        rs();
        apb(1'b0, 12'h010, 32'h0, 32'h2, 1'b0);
        set(0, 16'd1000, 16'd1500);
        rs();
        @(posedge clk);
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h17, 32'h0, 1'b0);
        pstrb <= 4'hf;
        apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
        wctl(0, 32'hffff_ffff);
        apb(1'b0, 12'h000, 32'h0, 32'h17, 1'b0);
        wctl(0, 32'h3);
        wctl(1, 32'h3);
        apb(1'b0, 12'h010, 32'h0, 32'h3, 1'b0);
        // Random levels on both channels, no hysteresis
        repeat (24) begin
            @(posedge clk);
            seed = rnd(seed);
            pos <= seed & 32'h0fff_0fff;
            seed = rnd(seed);
            pin <= seed & 32'h0fff_0fff;
            settle();
            rs();
            clr(seed[17:16]);
        end
        close_out();
    end
endmodule : analog_comparator_ctrl_tb
`default_nettype wire
